// [logic/rsc_pkg.sv]
/*
 * Shared constants and state type for the reset strap configuration select block.
 * Assumes one device clock (mclk, 10 MHz) and an asynchronous active-low master reset.
 */
package rsc_pkg;
   // pin bank and index widths
   localparam int          NUM_GPIO    = 16;
   localparam int          IDX_W       = 16;
   localparam int          OUT_W       = 8;
   // fixed strap pins
   localparam int          PIN_PROTO   = 9;
   localparam int          PIN_HOLD_HI = 8;
   // default selection pins when no pin is assigned
   localparam int          DEF_SEL_LSB = 0;
   localparam int          DEF_SEL_W   = 4;
   // reset values
   localparam logic [15:0] PINS_RST    = 16'hffff;
   localparam logic [15:0] IDX_RST     = 16'h000f;
   localparam logic [15:0] MASK_NONE   = 16'h0000;
   localparam logic [7:0]  OUT_EN_RST  = 8'h00;
   localparam logic [15:0] GPIO_OE_RST = 16'h0000;
   // host override selectors
   localparam logic [2:0]  HSEL_PROTO  = 3'h0;
   localparam logic [2:0]  HSEL_ADDR   = 3'h1;
   localparam logic [2:0]  HSEL_EEDIS  = 3'h2;
   localparam logic [2:0]  HSEL_INDEX  = 3'h3;
   localparam logic [2:0]  HSEL_OUTEN  = 3'h4;
   localparam logic [2:0]  HSEL_GPIOOE = 3'h5;
   localparam logic [2:0]  HSEL_DPLL   = 3'h6;

   // startup sequence states, one-hot
   typedef enum logic [5:0] {
      ST_CAPTURE = 6'h01,
      ST_INFO    = 6'h02,
      ST_CLOCKS  = 6'h04,
      ST_OTP     = 6'h08,
      ST_EEPROM  = 6'h10,
      ST_RUN     = 6'h20
   } rsc_state_e;
endpackage

// [logic/rsc_strap_if.sv]
/*
 * Carrier between the capture latch, the pin-function decoder and the sequencer.
 * Assumes all three parties sit in the mclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface rsc_strap_if;
   logic [15:0] pins;       // captured pin levels
   logic        captured;   // capture done since reset
   logic [15:0] addr_mask;  // pins given the address-strap function
   logic [15:0] eedis_mask; // pins given the eeprom-disable function
   logic [15:0] sel_mask;   // pins given the config-select function
   logic        addr_bit;   // decoded slave address bit 2
   logic        eedis;      // decoded eeprom disable
   logic [15:0] index;      // decoded configuration index

   modport cap (output pins, output captured);
   modport dec (input pins, input addr_mask, input eedis_mask, input sel_mask,
                output addr_bit, output eedis, output index);
   modport seq (input pins, input captured, output addr_mask, output eedis_mask,
                output sel_mask, input addr_bit, input eedis, input index);
endinterface
`default_nettype wire

// [logic/rsc_capture.sv]
/*
 * Strap capture latch: takes every pin level once, just after master reset releases.
 * Assumes gpio_in is synchronous to mclk and settled while reset is held.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_capture (
   input  wire logic        mclk,    // device clock
   input  wire logic        arst_n,  // master reset, active low
   input  wire logic [15:0] gpio_in, // pin levels
   rsc_strap_if.cap         st       // captured levels out
);
   logic [15:0] next_pins;
   logic        next_captured;

   ////////////////////////////////////////////////////////////////////////////
   // take the pins on the first edge after release, then freeze
   always_comb begin
      next_pins     = st.pins;
      next_captured = st.captured;
      if (!st.captured) begin
         next_pins     = gpio_in;
         next_captured = 1'b1;
      end
   end

   // reset loads constants only; the real sample comes from the clocked path
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st.pins     <= rsc_pkg::PINS_RST;
         st.captured <= 1'b0;
      end else begin
         st.pins     <= next_pins;
         st.captured <= next_captured;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_CAPTURE_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      st.captured |=> (st.pins == $past(st.pins)) && st.captured)
      else $error("captured straps changed after capture");
endmodule
`default_nettype wire

// [logic/rsc_decode.sv]
/*
 * Pin-function decoder: turns the captured levels and the function masks into
 * the address bit, the eeprom disable and the configuration index.
 * Assumes masks are stable once the device information block has been read.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_decode (
   rsc_strap_if.dec st      // masks and levels in, decoded values out
);
   ////////////////////////////////////////////////////////////////////////////
   // one pass over the pins; later (higher) pins overwrite the address bit
   always_comb begin
      logic [4:0]  k;
      logic [15:0] idx;
      logic        abit;
      k    = 5'h00;
      idx  = 16'h0000;
      abit = 1'b0;
      for (int i = 0; i < rsc_pkg::NUM_GPIO; i++) begin
         if (st.addr_mask[i]) begin
            abit = st.pins[i];
         end
         if (st.sel_mask[i]) begin
            idx[k[3:0]] = st.pins[i];
            k = k + 5'h01;
         end
      end
      if (st.sel_mask == rsc_pkg::MASK_NONE) begin
         idx = {12'h000, st.pins[rsc_pkg::DEF_SEL_LSB +: rsc_pkg::DEF_SEL_W]};
      end
      st.addr_bit = abit;
      st.index    = idx;
      st.eedis    = |(st.eedis_mask & st.pins);
   end
endmodule
`default_nettype wire

// [logic/rsc_top.sv]
/*
 * Reset strap configuration select: startup sequencer that samples the pins at
 * master reset release, applies strap-derived settings, requests the stored
 * configuration, optionally searches the eeprom, and holds neutral defaults.
 * Assumes an otp reader, clock bring-up and eeprom searcher outside, each with
 * a request/done handshake, and a host port that may overwrite any setting.
 */
// Notes on behaviour
// - sample all pins when reset releases
// - pin 9 low SPI, high I2C
// - address strap sets bit 2, else zero
// - address strap ignored when SPI selected
// - highest-index address strap pin wins
// - high eeprom-disable pin skips eeprom reads
// - no disable pin means eeprom search
// - any disable pin high disables eeprom
// - no select pins uses pins 3..0
// - undriven default pins give index 15
// - select pins ordered, lowest is LSB
// - fewer than four pins, upper bits zero
// - more than four pins widen index
// - index picks stored config, unprogrammed ignores
// - pin functions come from info block
// - every strap setting stays host writable
// - defaults: outputs off, pins inputs
// - clocks and loop lock before config use
// - bad checksum keeps register defaults
`timescale 1ns/1ps
`default_nettype none
module rsc_top (
   input  wire logic        mclk,            // device clock, 10 MHz
   input  wire logic        arst_n,          // master reset, active low
   input  wire logic [15:0] gpio_in,         // general-purpose pin levels
   input  wire logic        info_valid,      // device info block read
   input  wire logic [15:0] info_addr_mask,  // address-strap pin map
   input  wire logic [15:0] info_eedis_mask, // eeprom-disable pin map
   input  wire logic [15:0] info_sel_mask,   // config-select pin map
   input  wire logic        clocks_ready,    // clocks up, loop calibrated and locked
   input  wire logic        otp_has_cfg,     // otp holds stored configurations
   input  wire logic        otp_load_done,   // stored config read finished
   input  wire logic        otp_csum_ok,     // stored config checksum good
   input  wire logic [7:0]  cfg_out_en,      // loaded output enables
   input  wire logic [15:0] cfg_gpio_oe,     // loaded pin directions
   input  wire logic        cfg_dpll_en,     // loaded loop enable
   input  wire logic        eeprom_done,     // eeprom search finished
   input  wire logic        host_wr,         // host override strobe
   input  wire logic [2:0]  host_sel,        // host override target
   input  wire logic [15:0] host_wdata,      // host override value
   output logic             clk_bringup_req, // start clocks and loop lock
   output logic             otp_load_req,    // request stored config load
   output logic [15:0]      cfg_index,       // selected configuration index
   output logic             eeprom_search_req, // request eeprom search
   output logic             host_is_i2c,     // main port protocol, 1 = I2C
   output logic             slave_addr_bit2, // slave address bit 2
   output logic             eeprom_disable,  // eeprom accesses disabled
   output logic             cfg_loaded,      // stored config applied
   output logic [7:0]       out_en,          // clock output enables
   output logic [15:0]      gpio_oe,         // pin output enables
   output logic             dpll_en,         // further loops may start
   output logic             pin8_low_fault,  // pin 8 seen low at capture
   output logic             startup_done     // sequence complete
);
   rsc_strap_if st ();

   rsc_pkg::rsc_state_e state;
   rsc_pkg::rsc_state_e next_state;
   logic                next_host_is_i2c;
   logic                next_slave_addr_bit2;
   logic                next_eeprom_disable;
   logic [15:0]         next_cfg_index;
   logic                next_cfg_loaded;
   logic [7:0]          next_out_en;
   logic [15:0]         next_gpio_oe;
   logic                next_dpll_en_cfg;
   logic                dpll_en_cfg;
   logic                next_pin8_low_fault;

   ////////////////////////////////////////////////////////////////////////////
   // capture and decode
   rsc_capture u_capture (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .gpio_in (gpio_in),
      .st      (st)
   );

   rsc_decode u_decode (
      .st (st)
   );

   // pin functions come straight from the device information block
   assign st.addr_mask  = info_addr_mask;
   assign st.eedis_mask = info_eedis_mask;
   assign st.sel_mask   = info_sel_mask;

   ////////////////////////////////////////////////////////////////////////////
   // startup sequencer and settings
   always_comb begin
      next_state           = state;
      next_host_is_i2c     = host_is_i2c;
      next_slave_addr_bit2 = slave_addr_bit2;
      next_eeprom_disable  = eeprom_disable;
      next_cfg_index       = cfg_index;
      next_cfg_loaded      = cfg_loaded;
      next_out_en          = out_en;
      next_gpio_oe         = gpio_oe;
      next_dpll_en_cfg     = dpll_en_cfg;
      next_pin8_low_fault  = pin8_low_fault;
      case (state)
         rsc_pkg::ST_CAPTURE: begin
            if (st.captured) begin
               next_state = rsc_pkg::ST_INFO;
            end
         end
         rsc_pkg::ST_INFO: begin
            // wait for the pin map before deciding; levels are already frozen
            if (info_valid) begin
               next_host_is_i2c     = st.pins[rsc_pkg::PIN_PROTO];
               next_slave_addr_bit2 = st.pins[rsc_pkg::PIN_PROTO] & st.addr_bit;
               next_eeprom_disable  = st.eedis;
               next_cfg_index       = st.index;
               next_pin8_low_fault  = ~st.pins[rsc_pkg::PIN_HOLD_HI];
               next_state           = rsc_pkg::ST_CLOCKS;
            end
         end
         rsc_pkg::ST_CLOCKS: begin
            // nothing from the stored config is used before the loop is locked
            if (clocks_ready) begin
               if (otp_has_cfg) begin
                  next_state = rsc_pkg::ST_OTP;
               end else begin
                  next_state = rsc_pkg::ST_EEPROM;
               end
            end
         end
         rsc_pkg::ST_OTP: begin
            if (otp_load_done) begin
               if (otp_csum_ok) begin
                  next_out_en      = cfg_out_en;
                  next_gpio_oe     = cfg_gpio_oe;
                  next_dpll_en_cfg = cfg_dpll_en;
                  next_cfg_loaded  = 1'b1;
               end
               // bad checksum: registers stay at their defaults
               next_state = rsc_pkg::ST_EEPROM;
            end
         end
         rsc_pkg::ST_EEPROM: begin
            if (eeprom_disable || eeprom_done) begin
               next_state = rsc_pkg::ST_RUN;
            end
         end
         rsc_pkg::ST_RUN: begin
            next_state = rsc_pkg::ST_RUN;
         end
         default: begin
            next_state = rsc_pkg::ST_CAPTURE;
         end
      endcase
      // host writes win over strap and config values in the same cycle
      if (host_wr) begin
         case (host_sel)
            rsc_pkg::HSEL_PROTO:  next_host_is_i2c     = host_wdata[0];
            rsc_pkg::HSEL_ADDR:   next_slave_addr_bit2 = host_wdata[0];
            rsc_pkg::HSEL_EEDIS:  next_eeprom_disable  = host_wdata[0];
            rsc_pkg::HSEL_INDEX:  next_cfg_index       = host_wdata;
            rsc_pkg::HSEL_OUTEN:  next_out_en          = host_wdata[7:0];
            rsc_pkg::HSEL_GPIOOE: next_gpio_oe         = host_wdata;
            rsc_pkg::HSEL_DPLL:   next_dpll_en_cfg     = host_wdata[0];
            default: begin
               next_dpll_en_cfg = next_dpll_en_cfg;
            end
         endcase
      end
   end

   // neutral defaults: outputs off, pins as inputs, default index 15
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state           <= rsc_pkg::ST_CAPTURE;
         host_is_i2c     <= 1'b1;
         slave_addr_bit2 <= 1'b0;
         eeprom_disable  <= 1'b0;
         cfg_index       <= rsc_pkg::IDX_RST;
         cfg_loaded      <= 1'b0;
         out_en          <= rsc_pkg::OUT_EN_RST;
         gpio_oe         <= rsc_pkg::GPIO_OE_RST;
         dpll_en_cfg     <= 1'b0;
         pin8_low_fault  <= 1'b0;
      end else begin
         state           <= next_state;
         host_is_i2c     <= next_host_is_i2c;
         slave_addr_bit2 <= next_slave_addr_bit2;
         eeprom_disable  <= next_eeprom_disable;
         cfg_index       <= next_cfg_index;
         cfg_loaded      <= next_cfg_loaded;
         out_en          <= next_out_en;
         gpio_oe         <= next_gpio_oe;
         dpll_en_cfg     <= next_dpll_en_cfg;
         pin8_low_fault  <= next_pin8_low_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // handshake requests are decoded from the state
   assign clk_bringup_req   = (state == rsc_pkg::ST_CLOCKS);
   assign otp_load_req      = (state == rsc_pkg::ST_OTP);
   assign eeprom_search_req = (state == rsc_pkg::ST_EEPROM) && !eeprom_disable;
   assign startup_done      = (state == rsc_pkg::ST_RUN);
   // further loops only run when the configuration asks for them
   assign dpll_en           = startup_done && dpll_en_cfg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_PROTO_APPLY: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr
      |=> host_is_i2c == $past(st.pins[rsc_pkg::PIN_PROTO]))
      else $error("protocol not taken from pin 9");

   AST_ADDR_SPI: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr && !st.pins[rsc_pkg::PIN_PROTO]
      |=> !slave_addr_bit2)
      else $error("address strap acted under SPI");

   AST_ADDR_DEFAULT: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr && (info_addr_mask == 16'h0000)
      |=> !slave_addr_bit2)
      else $error("address bit not zero without strap pin");

   AST_EEDIS_ANY: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr
      |=> eeprom_disable == $past(|(info_eedis_mask & st.pins)))
      else $error("eeprom disable not the or of its pins");

   AST_DEFAULT_INDEX: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr && (info_sel_mask == 16'h0000)
      |=> cfg_index == {12'h000, $past(st.pins[3:0])})
      else $error("default index not from pins 3..0");

   AST_CSUM_FAIL: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_OTP) && otp_load_done && !otp_csum_ok && !host_wr
      |=> !cfg_loaded && $stable(out_en) && $stable(gpio_oe))
      else $error("bad checksum config was applied");

   AST_NO_EEPROM: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_EEPROM) && eeprom_disable
      |-> !eeprom_search_req ##1 (state == rsc_pkg::ST_RUN))
      else $error("eeprom searched while disabled");

   AST_CLOCKS_FIRST: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(otp_load_req) |-> $past(clocks_ready) && $past(clk_bringup_req))
      else $error("config load before clocks ready");

   AST_UNPROGRAMMED: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_CLOCKS) && clocks_ready && !otp_has_cfg
      |=> !otp_load_req [*2])
      else $error("config load on unprogrammed device");

   AST_DEFAULTS: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_CAPTURE) |-> (out_en == 8'h00) && (gpio_oe == 16'h0000))
      else $error("outputs not neutral at startup");

   // pin 8 fault only mirrors the capture
   AST_PIN8_FLAG: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid
      |=> pin8_low_fault == !$past(st.pins[rsc_pkg::PIN_HOLD_HI]))
      else $error("pin 8 fault flag wrong");

   // the latch takes the pins once, at release
   AST_CAPTURE_ONCE: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(st.captured)
      |-> st.pins == $past(gpio_in))
      else $error("straps not taken at release");

   // index register follows the decoder
   AST_INDEX_APPLY: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr
      |=> cfg_index == $past(st.index))
      else $error("index not taken at apply");

   // under I2C the address bit follows the strap
   AST_ADDR_APPLY: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_INFO) && info_valid && !host_wr && st.pins[rsc_pkg::PIN_PROTO]
      |=> slave_addr_bit2 == $past(st.addr_bit))
      else $error("address bit not from strap");

   // no disable: the search is asked for
   AST_EE_SEARCH: assert property (@(posedge mclk) disable iff (!arst_n)
      (state == rsc_pkg::ST_CLOCKS) && clocks_ready && !otp_has_cfg && !eeprom_disable
      && !host_wr |=> eeprom_search_req)
      else $error("eeprom search not requested");

   // a host write lands one cycle later
   AST_HOST_INDEX: assert property (@(posedge mclk) disable iff (!arst_n)
      host_wr && (host_sel == rsc_pkg::HSEL_INDEX)
      |=> cfg_index == $past(host_wdata))
      else $error("host index write lost");
endmodule
`default_nettype wire

// [tb/rsc_partner.sv]
/*
 * Far-side model for rsc_top: board straps with pull-ups on every pin, plus the
 * clock bring-up, otp reader and eeprom searcher that answer its requests.
 * Assumes the bench sets the strap pattern before master reset releases.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_partner (
   input  wire logic        mclk,              // device clock
   input  wire logic        arst_n,            // master reset, active low
   input  wire logic [15:0] drv_mask,          // pins strapped by the board
   input  wire logic [15:0] drv_val,           // levels of strapped pins
   input  wire logic [3:0]  dly,               // answer delay in cycles
   input  wire logic        clk_bringup_req,   // clock bring-up request
   input  wire logic        otp_load_req,      // otp load request
   input  wire logic        eeprom_search_req, // eeprom search request
   output logic [15:0]      gpio_in,           // pin levels seen by the device
   output logic             clocks_ready,      // clocks locked, level
   output logic             otp_load_done,     // otp load finished, one cycle
   output logic             eeprom_done        // eeprom search finished, one cycle
);
   logic [2:0]  reqs;
   logic [2:0]  prev;
   logic [3:0]  cnt;
   logic [1:0]  since;
   logic [15:0] strap;
   logic        go;

   ////////////////////////////////////////////////////////////////////////////////
   // undriven pins float to the pull-up level
   assign strap = (drv_val & drv_mask) | ~drv_mask;
   // pin 8 stays high through reset; after capture the pins turn into plain gpio,
   // so they show the opposite level to expose any late sampling
   assign gpio_in = (since == 2'h3) ? ~strap : (strap | 16'h0100);
   assign reqs = {eeprom_search_req, otp_load_req, clk_bringup_req};
   // a request is answered only once it has stood dly cycles unchanged
   assign go = (reqs == prev) && (cnt == dly);

   ////////////////////////////////////////////////////////////////////////////////
   // request tracking and answers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         since <= 2'h0;
         prev <= 3'h0;
         cnt <= 4'h0;
         clocks_ready <= 1'b0;
         otp_load_done <= 1'b0;
         eeprom_done <= 1'b0;
      end else begin
         if (since != 2'h3) begin
            since <= since + 2'h1;
         end
         prev <= reqs;
         cnt <= (reqs != prev) ? 4'h0 : cnt + 4'h1;
         clocks_ready <= clocks_ready | (reqs[0] && go);
         otp_load_done <= reqs[1] && go;
         eeprom_done <= reqs[2] && go;
      end
   end
endmodule
`default_nettype wire

// [tb/rsc_top_bench.sv]
/*
 * Self-checking bench for rsc_top: boots under several strap patterns, and after
 * the first boot overrides every setting through the host strobe.
 * Assumes rsc_partner stands in for the straps and the startup helpers.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_top_bench;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic        otp_has_cfg = 1'b0;
   logic        otp_csum_ok = 1'b0;
   logic        host_wr = 1'b0;
   logic [2:0]  host_sel = 3'h0;
   logic [15:0] host_wdata = 16'h0000;
   logic [15:0] info_addr_mask = 16'h0000;
   logic [15:0] info_eedis_mask = 16'h0000;
   logic [15:0] info_sel_mask = 16'h0000;
   logic [15:0] drv_mask = 16'h0000;
   logic [15:0] drv_val = 16'h0000;
   logic [3:0]  dly = 4'h0;
   logic        info_valid = 1'b0;
   logic [15:0] gpio_in, cfg_index, gpio_oe;
   logic [7:0]  out_en;
   logic        clocks_ready, otp_load_done, eeprom_done, clk_bringup_req, otp_load_req;
   logic        eeprom_search_req, host_is_i2c, slave_addr_bit2, eeprom_disable, cfg_loaded;
   logic        dpll_en, pin8_low_fault, startup_done, saw_otp, saw_ee, ord_bad;
   logic [8:0]  flags;
   int          miscompares = 0;
   int          num_checks = 0;

   always #50 mclk = ~mclk;

   // stored config data is fixed; only its presence and checksum vary
   rsc_top DUT (.mclk(mclk), .arst_n(arst_n), .gpio_in(gpio_in), .info_valid(info_valid),
      .info_addr_mask(info_addr_mask), .info_eedis_mask(info_eedis_mask),
      .info_sel_mask(info_sel_mask), .clocks_ready(clocks_ready), .otp_has_cfg(otp_has_cfg),
      .otp_load_done(otp_load_done), .otp_csum_ok(otp_csum_ok), .cfg_out_en(8'h3c),
      .cfg_gpio_oe(16'h0101), .cfg_dpll_en(1'b1), .eeprom_done(eeprom_done),
      .host_wr(host_wr), .host_sel(host_sel), .host_wdata(host_wdata),
      .clk_bringup_req(clk_bringup_req), .otp_load_req(otp_load_req), .cfg_index(cfg_index),
      .eeprom_search_req(eeprom_search_req), .host_is_i2c(host_is_i2c),
      .slave_addr_bit2(slave_addr_bit2), .eeprom_disable(eeprom_disable),
      .cfg_loaded(cfg_loaded), .out_en(out_en), .gpio_oe(gpio_oe), .dpll_en(dpll_en),
      .pin8_low_fault(pin8_low_fault), .startup_done(startup_done));

   rsc_partner far_side (.mclk(mclk), .arst_n(arst_n), .drv_mask(drv_mask),
      .drv_val(drv_val), .dly(dly), .clk_bringup_req(clk_bringup_req),
      .otp_load_req(otp_load_req), .eeprom_search_req(eeprom_search_req),
      .gpio_in(gpio_in), .clocks_ready(clocks_ready), .otp_load_done(otp_load_done),
      .eeprom_done(eeprom_done));

   ////////////////////////////////////////////////////////////////////////////////
   // one word of status bits so a scenario compares them in one go
   assign flags = {host_is_i2c, slave_addr_bit2, eeprom_disable, cfg_loaded, dpll_en,
                   saw_otp, saw_ee, ord_bad, pin8_low_fault};

   // note which requests appeared; an otp request before lock is an order slip
   always @(posedge mclk) begin
      if (!arst_n) begin
         saw_otp <= 1'b0;
         saw_ee <= 1'b0;
         ord_bad <= 1'b0;
      end else begin
         saw_otp <= saw_otp | otp_load_req;
         saw_ee <= saw_ee | eeprom_search_req;
         ord_bad <= ord_bad | (otp_load_req & ~clocks_ready);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic verify(input logic [8:0] ef, input logic [15:0] ei,
                         input logic [7:0] eo, input logic [15:0] eg);
      check("startup_done", 16'(startup_done), 16'h0001);
      check("flags", 16'(flags), 16'(ef));
      check("cfg_index", cfg_index, ei);
      check("out_en", 16'(out_en), 16'(eo));
      check("gpio_oe", gpio_oe, eg);
   endtask

   // reset 16 cycles with a strap setup, then wait for the sequence to finish
   task automatic boot(input logic [15:0] dm, dv, am, em, sm, input logic hc, ok,
                       input logic [3:0] d);
      int i;
      @(posedge mclk);
      arst_n <= 1'b0;
      drv_mask <= dm;
      drv_val <= dv;
      info_addr_mask <= am;
      info_eedis_mask <= em;
      info_sel_mask <= sm;
      otp_has_cfg <= hc;
      otp_csum_ok <= ok;
      dly <= d;
      info_valid <= 1'b0;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (d) @(posedge mclk);
      info_valid <= 1'b1;
      for (i = 0; i < 300 && startup_done !== 1'b1; i++) begin
         @(negedge mclk);
      end
   endtask

   // one host strobe per edge, so calls in a row give back-to-back writes
   task automatic hw(input logic [2:0] s, input logic [15:0] d);
      @(posedge mclk);
      host_wr <= 1'b1;
      host_sel <= s;
      host_wdata <= d;
   endtask

   task finish_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // strap pins of each boot are kept apart and off the test port
   initial begin
      boot(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1, 4'h0);
      verify(9'h13c, 16'h000f, 8'h3c, 16'h0101);
      hw(rsc_pkg::HSEL_PROTO, 16'h0000);
      hw(rsc_pkg::HSEL_ADDR, 16'h0001);
      hw(rsc_pkg::HSEL_EEDIS, 16'h0001);
      hw(rsc_pkg::HSEL_INDEX, 16'h0abc);
      hw(rsc_pkg::HSEL_OUTEN, 16'h005a);
      hw(rsc_pkg::HSEL_GPIOOE, 16'h1234);
      hw(rsc_pkg::HSEL_DPLL, 16'h0000);
      hw(3'h7, 16'h00ff);
      @(posedge mclk);
      host_wr <= 1'b0;
      @(negedge mclk);
      verify(9'h0ec, 16'h0abc, 8'h5a, 16'h1234);
      // spi port: address strap ignored, default index pins, no stored configs
      boot(16'h02af, 16'h0085, 16'h00a0, 16'h0000, 16'h0000, 1'b0, 1'b1, 4'h3);
      verify(9'h004, 16'h0005, 8'h00, 16'h0000);
      // two address pins, two disable pins, scattered select pins, bad checksum
      boot(16'h3ce4, 16'h3484, 16'h00a0, 16'h1800, 16'h2444, 1'b1, 1'b0, 4'h1);
      verify(9'h1c8, 16'h000d, 8'h00, 16'h0000);
      // two select pins, disable pin held low
      boot(16'h4012, 16'h0012, 16'h0000, 16'h4000, 16'h0012, 1'b0, 1'b1, 4'h7);
      verify(9'h104, 16'h0003, 8'h00, 16'h0000);
      // six select pins widen the index
      boot(16'hc033, 16'h8031, 16'h0000, 16'h0000, 16'hc033, 1'b0, 1'b1, 4'h2);
      verify(9'h104, 16'h002d, 8'h00, 16'h0000);
      finish_test;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      finish_test;
   end
endmodule
`default_nettype wire
